// [inc/asp_pkg.sv]
/*
  Constants, field positions and state types of the asynchronous serial port.
  Assumes a 100 MHz system clock and an APB register bus with 32-bit data.
*/
`default_nettype none

package asp_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_RXH = 8'h00;
  localparam logic [7:0] ADDR_RXCS = 8'h04;
  localparam logic [7:0] ADDR_TXH = 8'h08;
  localparam logic [7:0] ADDR_TXCS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ = 8'h10;
  localparam logic [7:0] ADDR_BAUD = 8'h14;
  localparam logic [7:0] ADDR_ERRCLR = 8'h18;

  // ==========================================================================
  // Field positions
  localparam int TX_FULL_B = 0;
  localparam int TX_SHIFT_B = 1;
  localparam int LOOP_B = 2;
  localparam int BREAK_B = 3;
  localparam int RX_FULL_B = 0;
  localparam int RX_ACT_B = 1;
  localparam int RX_ERR_B = 2;
  localparam int RX_PIN_B = 3;
  localparam int EN_RXA_B = 0;
  localparam int EN_RXF_B = 1;
  localparam int EN_TXE_B = 2;
  localparam int SON_B = 3;
  localparam int BAUD_CLK_B = 3;

  // ==========================================================================
  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [2:0] BAUD_RST = 3'h0;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ==========================================================================
  // Timing
  localparam longint CLK_HZ = 100000000;
  localparam longint BASE_LO_HZ = 153600;
  localparam longint BASE_HI_HZ = 245760;
  localparam int NCO_W = 32;
  // The accumulator wraps at twice the base rate; each wrap is a half period
  localparam logic [63:0] NCO_LO64 = ((64'(BASE_LO_HZ) * 64'h2) << NCO_W) / 64'(CLK_HZ);
  localparam logic [63:0] NCO_HI64 = ((64'(BASE_HI_HZ) * 64'h2) << NCO_W) / 64'(CLK_HZ);
  localparam logic [31:0] NCO_INC_LO = NCO_LO64[31:0];
  localparam logic [31:0] NCO_INC_HI = NCO_HI64[31:0];
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] HALF_BIT_LAST = 4'h7;
  localparam logic [3:0] TX_LAST_BIT = 4'hA;
  localparam logic [3:0] RX_LAST_BIT = 4'h8;

  typedef enum logic {TX_IDLE, TX_SEND} asp_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_HOLDOFF} asp_rx_state_t;
endpackage : asp_pkg

`default_nettype wire

// [rtl/asp_top.sv]
/*
  Asynchronous serial port: APB slave registers, baud generator, start-bit
  filtered receiver and double-buffered transmitter, with loopback and break.
  Assumes line_in_i is synchronous to clk_i and that the APB master follows
  the usual setup/access sequence.
*/
// Overview of operation
// - Holding write stores byte, starts transmitter
// - Idle shifter takes held byte, clears full
// - Shifting flag set at load, cleared at frame end, not by break
// - Loopback feeds transmitter into receiver too
// - Break force holds line in space
// - Break aborts frame, starts transmit clock
// - Space runs to end of current bit after break
// - Service request on any enabled condition
// - Power off clears registers, line idle
// - Power off keeps baud selection
// - Three select bits choose eight rates
// - Sixteen-times clock, level readable, write ignored
// - Base 153600 or 245760 Hz divided by 1,2,4,8
// - Half-bit start filter, early mark aborts
// - Valid start sets active, enables shifting
// - Center sampling, completion at 9.5 bits
// - Completion stores byte, flags overrun/framing
// - Reading received byte clears full flag
// - Error clear port clears only error
// - Break gives zero byte, waits mark
// - Two stops, start, byte: 11 bits
// - Start zero, LSB first, stop ones
// - Receive status layout, pin bit readable
`timescale 1ns/10ps
`default_nettype none

module asp_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [asp_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Serial line
  input wire logic line_in_i,
  output logic line_out_o,
  output logic line_pwr_o,
  // Service request
  output logic serial_service_req_o
);
  import asp_pkg::*;

  // ==========================================================================
  // Register bus
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  wire access = psel_i && penable_i && pready_reg;
  wire wr = access && pwrite_i;
  wire rd = access && !pwrite_i;
  wire hit_rxh = (paddr_i == ADDR_RXH);
  wire hit_rxcs = (paddr_i == ADDR_RXCS);
  wire hit_txh = (paddr_i == ADDR_TXH);
  wire hit_txcs = (paddr_i == ADDR_TXCS);
  wire hit_irq = (paddr_i == ADDR_IRQ);
  wire hit_baud = (paddr_i == ADDR_BAUD);
  wire hit_errclr = (paddr_i == ADDR_ERRCLR);
  wire mapped = hit_rxh || hit_rxcs || hit_txh || hit_txcs || hit_irq || hit_baud || hit_errclr;

  logic [7:0] rx_hold_reg;
  logic [7:0] tx_hold_reg;
  logic [3:0] tx_cs_reg;
  logic [2:0] rx_cs_reg;
  logic [3:0] irq_reg;
  logic [2:0] baud_reg;
  logic serial_power_on;
  assign serial_power_on = irq_reg[SON_B];

  // ==========================================================================
  // Baud generator (runs whatever the power bit says)
  logic [31:0] nco_reg;
  logic [3:0] div_reg;
  logic clk16_reg;
  wire [32:0] nco_sum = {1'b0, nco_reg} + {1'b0, baud_reg[0] ? NCO_INC_HI : NCO_INC_LO};
  wire [1:0] div_sel = 2'(2'h3 - baud_reg[2:1]);
  wire clk16_next = div_reg[div_sel];
  wire tick = clk16_next && !clk16_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nco_reg <= 32'h0000_0000;
      div_reg <= 4'h0;
      clk16_reg <= 1'b0;
    end else begin
      nco_reg <= nco_sum[31:0];
      div_reg <= div_reg + {3'h0, nco_sum[32]};
      clk16_reg <= clk16_next;
    end
  end

  // ==========================================================================
  // Transmitter
  asp_tx_state_t tx_state;
  logic [10:0] tx_sh_reg;
  logic [3:0] tx_ph_reg;
  logic [3:0] tx_bit_reg;
  logic brk_tail_reg;
  logic line_out_reg;
  logic line_pwr_reg;
  wire line_break_force = tx_cs_reg[BREAK_B];
  wire wr_txh = wr && hit_txh;
  wire wr_txcs = wr && hit_txcs;
  wire tx_bit_end = tick && (tx_ph_reg == SUB_LAST);
  wire tx_done = (tx_state == TX_SEND) && tx_bit_end && (tx_bit_reg == TX_LAST_BIT);
  // No load during the break tail, or the full flag would drop with no frame sent
  wire tx_load = !line_break_force && !brk_tail_reg && tx_cs_reg[TX_FULL_B]
    && ((tx_state == TX_IDLE) || tx_done);
  wire [3:0] tx_cs_wr = wr_txcs ? pwdata_i[3:0] : tx_cs_reg;
  logic tx_full_next;
  logic tx_shift_next;
  always_comb begin
    tx_full_next = tx_cs_wr[TX_FULL_B];
    tx_shift_next = tx_cs_wr[TX_SHIFT_B];
    if (tx_load) begin
      tx_full_next = 1'b0;
      tx_shift_next = 1'b1;
    end else if (tx_done) begin
      tx_shift_next = 1'b0;
    end
    if (wr_txh) begin
      tx_full_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_state <= TX_IDLE;
      tx_cs_reg <= CTRL_RST;
      tx_hold_reg <= DATA_RST;
      tx_sh_reg <= 11'h7FF;
      tx_ph_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      brk_tail_reg <= 1'b0;
    end else if (!serial_power_on) begin
      tx_state <= TX_IDLE;
      tx_cs_reg <= CTRL_RST;
      tx_hold_reg <= DATA_RST;
      tx_sh_reg <= 11'h7FF;
      tx_ph_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      brk_tail_reg <= 1'b0;
    end else if (tx_cs_wr[BREAK_B]) begin
      tx_state <= TX_IDLE;
      tx_cs_reg <= tx_cs_wr;
      tx_sh_reg <= 11'h7FF;
      tx_bit_reg <= 4'h0;
      tx_ph_reg <= line_break_force ? tx_ph_reg + {3'h0, tick} : 4'h0;
      brk_tail_reg <= 1'b1;
      if (wr_txh) begin
        tx_hold_reg <= pwdata_i[7:0];
        tx_cs_reg[TX_FULL_B] <= 1'b1;
      end
    end else begin
      tx_cs_reg <= {tx_cs_wr[BREAK_B:LOOP_B], tx_shift_next, tx_full_next};
      if (wr_txh) begin
        tx_hold_reg <= pwdata_i[7:0];
      end
      if (brk_tail_reg) begin
        tx_ph_reg <= tx_ph_reg + {3'h0, tick};
        if (tx_bit_end) begin
          brk_tail_reg <= 1'b0;
        end
      end else if (tx_load) begin
        tx_state <= TX_SEND;
        tx_sh_reg <= {2'b11, tx_hold_reg, 1'b0};
        tx_ph_reg <= 4'h0;
        tx_bit_reg <= 4'h0;
      end else if (tx_done) begin
        tx_state <= TX_IDLE;
      end else if (tx_state == TX_SEND) begin
        tx_ph_reg <= tx_ph_reg + {3'h0, tick};
        if (tx_bit_end) begin
          tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
          tx_bit_reg <= tx_bit_reg + 4'h1;
        end
      end
    end
  end

  // Idle (power off) is line_pwr low; line_out then parks at mark level
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_out_reg <= 1'b1;
      line_pwr_reg <= 1'b0;
    end else begin
      line_pwr_reg <= serial_power_on;
      if (serial_power_on && (line_break_force || brk_tail_reg)) begin
        line_out_reg <= 1'b0;
      end else if (serial_power_on && tx_state == TX_SEND) begin
        line_out_reg <= tx_sh_reg[0];
      end else begin
        line_out_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Receiver
  asp_rx_state_t rx_state;
  logic [8:0] rx_sh_reg;
  logic [3:0] rx_ph_reg;
  logic [3:0] rx_bit_reg;
  // Loopback taps the registered line so the receiver sees exactly the pin
  wire rx_in = (serial_power_on && tx_cs_reg[LOOP_B]) ? line_out_reg : line_in_i;
  wire rx_samp = tick && (rx_ph_reg == SUB_LAST);
  wire rx_done = (rx_state == RX_DATA) && rx_samp && (rx_bit_reg == RX_LAST_BIT);
  wire rx_break = rx_done && !rx_in && (rx_sh_reg[8:1] == 8'h00);
  wire rx_accept = (rx_state == RX_START) && tick && rx_ph_reg == HALF_BIT_LAST && !rx_in;
  wire rd_rxh = rd && hit_rxh;
  wire wr_rxcs = wr && hit_rxcs;
  wire wr_errclr = wr && hit_errclr;
  logic [2:0] rx_cs_next;
  always_comb begin
    rx_cs_next = wr_rxcs ? pwdata_i[2:0] : rx_cs_reg;
    if (wr_errclr) begin
      rx_cs_next[RX_ERR_B] = 1'b0;
    end
    if (rd_rxh) begin
      rx_cs_next[RX_FULL_B] = 1'b0;
    end
    if (rx_accept) begin
      rx_cs_next[RX_ACT_B] = 1'b1;
    end
    if (rx_done) begin
      rx_cs_next[RX_FULL_B] = 1'b1;
      rx_cs_next[RX_ACT_B] = 1'b0;
      if (rx_cs_reg[RX_FULL_B] || !rx_in) begin
        rx_cs_next[RX_ERR_B] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_state <= RX_IDLE;
      rx_cs_reg <= 3'h0;
      rx_hold_reg <= DATA_RST;
      rx_sh_reg <= 9'h000;
      rx_ph_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
    end else if (!serial_power_on) begin
      rx_state <= RX_IDLE;
      rx_cs_reg <= 3'h0;
      rx_hold_reg <= DATA_RST;
      rx_sh_reg <= 9'h000;
      rx_ph_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
    end else begin
      rx_cs_reg <= rx_cs_next;
      if (wr && hit_rxh) begin
        rx_hold_reg <= pwdata_i[7:0];
      end
      case (rx_state)
        RX_IDLE: begin
          rx_ph_reg <= 4'h0;
          if (!rx_in) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_in) begin
            rx_state <= RX_IDLE;
          end else if (rx_accept) begin
            rx_state <= RX_DATA;
            rx_sh_reg <= 9'h000;
            rx_ph_reg <= 4'h0;
            rx_bit_reg <= 4'h0;
          end else begin
            rx_ph_reg <= rx_ph_reg + {3'h0, tick};
          end
        end
        RX_DATA: begin
          rx_ph_reg <= rx_ph_reg + {3'h0, tick};
          if (rx_samp) begin
            rx_sh_reg <= {rx_in, rx_sh_reg[8:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
          end
          if (rx_done) begin
            rx_hold_reg <= rx_sh_reg[8:1];
            rx_state <= rx_break ? RX_HOLDOFF : RX_IDLE;
          end
        end
        default: begin
          if (rx_in) begin
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Control registers and service request
  logic svc_reg;
  wire svc_next = (irq_reg[EN_RXA_B] && rx_cs_reg[RX_ACT_B])
               || (irq_reg[EN_RXF_B] && rx_cs_reg[RX_FULL_B])
               || (irq_reg[EN_TXE_B] && !tx_cs_reg[TX_FULL_B]);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_reg <= CTRL_RST;
      baud_reg <= BAUD_RST;
      svc_reg <= 1'b0;
    end else begin
      if (wr && hit_irq) begin
        // Enables only stick when the same write also turns the port on
        irq_reg <= pwdata_i[SON_B] ? pwdata_i[3:0] : CTRL_RST;
      end else if (!serial_power_on) begin
        irq_reg <= CTRL_RST;
      end
      if (wr && hit_baud) begin
        baud_reg <= pwdata_i[2:0];
      end
      svc_reg <= svc_next && serial_power_on;
    end
  end

  // ==========================================================================
  // Read mux; pready comes one cycle into the access phase
  logic [31:0] rdata;
  assign rdata = hit_rxh ? {24'h000000, rx_hold_reg}
    : hit_rxcs ? {28'h0000000, serial_power_on ? rx_in : 1'b1, rx_cs_reg}
    : hit_txh ? {24'h000000, tx_hold_reg}
    : hit_txcs ? {28'h0000000, tx_cs_reg}
    : hit_irq ? {28'h0000000, irq_reg}
    : hit_baud ? {28'h0000000, clk16_reg, baud_reg}
    : 32'h0000_0000;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel_i && penable_i && !pready_reg;
      prdata_reg <= (psel_i && !pwrite_i) ? rdata : 32'h0000_0000;
      pslverr_reg <= psel_i && penable_i && !pready_reg && !mapped;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign line_out_o = line_out_reg;
  assign line_pwr_o = line_pwr_reg;
  assign serial_service_req_o = svc_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  tx_load_a : assert property (
    serial_power_on && !line_break_force && !brk_tail_reg && !wr_txcs && tx_state == TX_IDLE && tx_cs_reg[TX_FULL_B]
    && !wr_txh
    |=> tx_cs_reg[TX_SHIFT_B] && !tx_cs_reg[TX_FULL_B] && tx_state == TX_SEND)
    else $error("held byte not moved to shifter");
  brk_space_a : assert property (
    serial_power_on && line_break_force |=> !line_out_o ##1 !line_out_o)
    else $error("break did not hold space");
  power_off_a : assert property (
    !serial_power_on && !(wr && hit_irq) |=> tx_cs_reg == 4'h0 && rx_cs_reg == 3'h0 && irq_reg == 4'h0
    ##1 !line_pwr_o)
    else $error("power off did not clear port");
  svc_level_a : assert property (
    serial_power_on ##1 serial_power_on |-> serial_service_req_o == $past(svc_next))
    else $error("service request mismatch");
  rx_read_a : assert property (
    serial_power_on && rd_rxh && !rx_done |=> !rx_cs_reg[RX_FULL_B])
    else $error("read did not clear full");
  err_clear_a : assert property (
    serial_power_on && wr_errclr && !wr_rxcs && !rx_done && !rx_accept && !rd_rxh
    |=> !rx_cs_reg[RX_ERR_B] && $stable(rx_cs_reg[1:0]))
    else $error("error clear disturbed status");
  baud_hold_a : assert property (
    !(wr && hit_baud) |=> $stable(baud_reg))
    else $error("baud select changed without write");
  overrun_a : assert property (
    serial_power_on && rx_done && rx_cs_reg[RX_FULL_B] |=> rx_cs_reg[RX_ERR_B] && rx_cs_reg[RX_FULL_B])
    else $error("overrun not flagged");
  start_accept_a : assert property (
    serial_power_on && rx_accept |=> rx_state == RX_DATA && rx_cs_reg[RX_ACT_B])
    else $error("valid start not accepted");
  loop_tap_a : assert property (
    serial_power_on && tx_cs_reg[LOOP_B] |-> rx_in == line_out_o)
    else $error("loopback path broken");

  tx_frame_c : cover property (tx_done ##1 tx_state == TX_IDLE);
  rx_frame_c : cover property (rx_done && !rx_break);
  rx_break_c : cover property (rx_break ##1 rx_state == RX_HOLDOFF);
  loop_c : cover property (rx_done && tx_cs_reg[LOOP_B]);
endmodule : asp_top

`default_nettype wire

// [test/asp_remote.sv]
/*
  Behavioural model of the remote serial station on the far side of the line.
  Assumes 15360 baud framing and that the bench runs the port at that rate.
*/
`timescale 1ns/10ps
`default_nettype none

module asp_remote #(
  parameter real BIT_NS = 65104.17
) (
  // Clock for stimulus timing
  input wire logic clk_i,
  // Port side of the line
  input wire logic line_i,
  input wire logic pwr_i,
  output logic line_o
);
  int frames;
  logic [7:0] last_byte;
  logic [7:0] shift_byte;
  logic frame_ok;

  initial begin
    line_o = 1'b1;
    frames = 0;
    last_byte = 8'h00;
    shift_byte = 8'h00;
    frame_ok = 1'b0;
  end

  // ==========================================================================
  // Frame receiver: samples at bit centres from the falling start edge
  always begin
    @(negedge line_i);
    if (pwr_i === 1'b1) begin
      #(BIT_NS / 2.0);
      frame_ok = (line_i === 1'b0);
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        shift_byte[i] = line_i;
      end
      repeat (2) begin
        #(BIT_NS);
        frame_ok = frame_ok & (line_i === 1'b1);
      end
      last_byte = shift_byte;
      frames++;
    end
  end

  // ==========================================================================
  // Short space pulse, shorter than a half bit, to exercise the start filter
  task automatic send_space(input int cycles);
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (cycles) @(posedge clk_i);
    line_o <= 1'b1;
  endtask : send_space
endmodule : asp_remote

`default_nettype wire

// [test/async_serial_port_tb.sv]
/*
  Self-checking bench for the serial port: APB register tasks and scenarios.
  Assumes the port at its fastest rate and a remote station model on the line.
*/
`timescale 1ns/10ps
`default_nettype none

module async_serial_port_tb;
  import asp_pkg::*;
  logic clk_i, resetn_i, psel_i, penable_i, pwrite_i, line_in_i;
  logic [ADDR_W-1:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, v;
  logic pready_o, pslverr_o, line_out_o, line_pwr_o, serial_service_req_o, e, s0, s1;
  int num_errors = 0;
  int samples_checked = 0;
  int n;

  asp_top i_asp_top (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .line_in_i(line_in_i), .line_out_o(line_out_o), .line_pwr_o(line_pwr_o),
    .serial_service_req_o(serial_service_req_o));

  asp_remote i_asp_remote (.clk_i(clk_i), .line_i(line_out_o), .pwr_i(line_pwr_o),
    .line_o(line_in_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Verdict and checking
  task automatic stop_test();
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ==========================================================================
  // APB master: hold the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int k;
    k = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    r = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (k >= 50) check("pready", 32'h0, 32'h1);
  endtask : apb

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic err;
    apb(1'b0, a, 32'h0, r, err);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic err;
    apb(1'b1, a, d, r, err);
  endtask : wr

  task automatic svc_is(input logic exp);
    repeat (2) @(posedge clk_i);
    check("service_req", {31'h0, serial_service_req_o}, {31'h0, exp});
  endtask : svc_is

  // Long waits are bounded so a stuck port ends the run
  initial begin
    #(950_000);
    num_errors++;
    stop_test();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    resetn_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(ADDR_RXCS, v); check("rx_ctrl_stat", v, 32'h8);
    rd(ADDR_TXCS, v); check("tx_ctrl_stat", v, 32'h0);
    rd(ADDR_IRQ, v); check("serial_irq_ctrl", v, 32'h0);
    rd(ADDR_BAUD, v); check("baud_select", v & 32'h7, 32'h0);
    check("line_pwr", {31'h0, line_pwr_o}, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, v, e);
    check("unmapped_err", {v[30:0], e}, 32'h1);
    // Writes while powered down are discarded, except to the baud select and writes that set the power bit
    wr(ADDR_TXH, 32'h55);
    rd(ADDR_TXCS, v); check("tx_ctrl_off", v, 32'h0);
    wr(ADDR_BAUD, 32'hF);
    wr(ADDR_IRQ, 32'h8);
    wr(ADDR_IRQ, 32'h0);
    rd(ADDR_BAUD, v); check("baud_kept", v & 32'h7, 32'h7);
    wr(ADDR_IRQ, 32'h8);
    repeat (2) @(posedge clk_i);
    check("line_on", {30'h0, line_pwr_o, line_out_o}, 32'h3);
    // The 16x clock level must be seen both high and low
    s0 = 1'b0;
    s1 = 1'b0;
    for (int i = 0; i < 300; i++) begin
      rd(ADDR_BAUD, v);
      if (v[3] === 1'b1) s1 = 1'b1;
      if (v[3] === 1'b0) s0 = 1'b1;
    end
    check("baud_clk_level", {30'h0, s1, s0}, 32'h3);
    wr(ADDR_IRQ, 32'hC);
    svc_is(1'b1);
    wr(ADDR_IRQ, 32'h8);
    svc_is(1'b0);
    wr(ADDR_RXCS, 32'h5);
    wr(ADDR_IRQ, 32'hA);
    svc_is(1'b1);
    wr(ADDR_ERRCLR, 32'h0);
    rd(ADDR_RXCS, v); check("error_cleared", v & 32'h7, 32'h1);
    rd(ADDR_RXH, v);
    rd(ADDR_RXCS, v); check("full_cleared", v & 32'h7, 32'h0);
    svc_is(1'b0);
    // Start pulse shorter than half a bit must be abandoned
    wr(ADDR_IRQ, 32'h9);
    i_asp_remote.send_space(1500);
    repeat (10) @(posedge clk_i);
    rd(ADDR_RXCS, v); check("glitch_rx", v & 32'h7, 32'h0);
    svc_is(1'b0);
    // Loopback frame: the receiver gets it and the line still carries it
    wr(ADDR_TXCS, 32'h4);
    wr(ADDR_IRQ, 32'hA);
    wr(ADDR_TXH, 32'hA5);
    rd(ADDR_TXCS, v); check("tx_started", v, 32'h6);
    n = 0;
    while (serial_service_req_o !== 1'b1 && n < 75000) begin
      @(posedge clk_i);
      n++;
    end
    check("rx_done", {31'h0, serial_service_req_o}, 32'h1);
    rd(ADDR_RXH, v); check("rx_byte", v, 32'hA5);
    rd(ADDR_RXCS, v); check("rx_stat_after", v & 32'h7, 32'h0);
    n = 0;
    do begin
      rd(ADDR_TXCS, v);
      n++;
    end while (v[1] === 1'b1 && n < 5000);
    check("tx_idle", v, 32'h4);
    check("remote_byte", {i_asp_remote.frame_ok, 23'h0, i_asp_remote.last_byte},
          32'h800000A5);
    check("remote_frames", 32'(i_asp_remote.frames), 32'h1);
    // Break: forced space, then released within about one bit
    wr(ADDR_TXCS, 32'h8);
    repeat (3) @(posedge clk_i);
    check("break_line", {31'h0, line_out_o}, 32'h0);
    rd(ADDR_TXCS, v); check("break_stat", v, 32'h8);
    wr(ADDR_TXCS, 32'h0);
    n = 0;
    while (line_out_o !== 1'b1 && n < 8000) begin
      @(posedge clk_i);
      n++;
    end
    check("break_end", {31'h0, line_out_o}, 32'h1);
    stop_test();
  end
endmodule : async_serial_port_tb

`default_nettype wire
